//--- src/cdoc_defs.svh
`ifndef CDOC_DEFS_SVH
`define CDOC_DEFS_SVH
`define CDOC_ADDR_COUNTS 10'h199
`define CDOC_ADDR_CTRL 10'h19a
`define CDOC_ADDR_POWER 10'h19b
`define CDOC_ADDR_VCO 10'h1e1
`define CDOC_CTRL_BYPASS 7
`define CDOC_CTRL_IGNSYNC 6
`define CDOC_CTRL_FORCE 5
`define CDOC_CTRL_START 4
`define CDOC_CTRL_PHASE 0
`define CDOC_PWR_DOWN 2
`define CDOC_PWR_DIRECT 1
`define CDOC_PWR_DCCDIS 0
`define CDOC_VCO_BYPASS 0
`define CDOC_CNT_LOW 4
`define CDOC_CNT_HIGH 0
`define CDOC_PWR_USED 8'h07
`define CDOC_VCO_USED 8'h01
`define CDOC_RESET_BYTE 8'h00
`endif

//--- src/cdoc_divider.sv
`include "cdoc_defs.svh"
module cdoc_divider
    import cdoc_pkg::*;
#(
    parameter int CW = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // configuration
    input wire logic [CW-1:0] low_cnt_in,
    input wire logic [CW-1:0] high_cnt_in,
    input wire logic [CW-1:0] phase_in,
    input wire logic start_high_in,
    input wire logic restart_in,
    input wire logic static_in,
    input wire logic static_level_in,
    // divided output
    output logic div_out
);
    cdoc_state_type state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic lvl_reg, lvl_next;
    wire logic [CW-1:0] phase_len = lvl_reg ? high_cnt_in : low_cnt_in;
    wire logic cnt_done = (cnt_reg == phase_len);

    // next-state logic: wait offset, then toggle
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        lvl_next = lvl_reg;
        case (state_reg)
            CDOC_IDLE: begin
                state_next = CDOC_WAIT;
                cnt_next = '0;
                lvl_next = start_high_in;
            end
            CDOC_WAIT: begin
                if (cnt_reg >= phase_in) begin
                    state_next = CDOC_RUN;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                if (cnt_done) begin
                    cnt_next = '0;
                    lvl_next = ~lvl_reg;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        endcase
        if (restart_in || static_in) begin
            state_next = CDOC_IDLE;
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= CDOC_IDLE;
            cnt_reg <= '0;
            lvl_reg <= 1'b0;
            div_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            lvl_reg <= lvl_next;
            div_out <= static_in ? static_level_in : lvl_next;
        end
    end
endmodule

//--- src/cdoc_pkg.sv
package cdoc_pkg;
    // software write request
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
    } cdoc_wr_type;
    // divider state machine, gray along idle-wait-run
    typedef enum logic [1:0] {
        CDOC_IDLE = 2'b00,
        CDOC_WAIT = 2'b01,
        CDOC_RUN = 2'b11
    } cdoc_state_type;
endpackage

//--- src/cdoc_top.sv
// Local design decision: strobed register access.
`include "cdoc_defs.svh"
module cdoc_top
    import cdoc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // chip-level links
    input wire logic sync_in,
    input wire logic [1:0] polarity_inv_in,
    // channel outputs
    output logic channel_three_output_a_out,
    output logic channel_three_output_b_out,
    output logic channel_three_output_c_out,
    output logic channel_powered_down_out,
    output logic duty_cycle_fix_en_out
);
    // internal reset copy
    logic [1:0] rst_sync_reg;
    wire logic rst_n = rst_sync_reg[1];
    // register copies
    logic [7:0] divider_three_counts_reg;
    logic [7:0] divider_three_control_reg;
    logic [7:0] channel_three_power_routing_reg;
    logic [7:0] vco_bypass_reg;
    // read path, sync flop, outputs
    logic [7:0] rdata_next;
    logic sync_reg;
    logic [2:0] out_reg;
    logic div_clk;

    // reset release through two flops; assertion stays asynchronous, release is
    // clocked so that every register leaves reset on the same edge
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // address match, shared by the write and the read decode
    function automatic logic addr_hit(input logic [9:0] addr, input logic [9:0] target);
        return addr == target;
    endfunction

    // write decode; an address that matches nothing is dropped silently
    wire cdoc_wr_type wr = '{addr: reg_addr_in, data: reg_wdata_in};
    wire logic wr_counts = reg_wr_in && addr_hit(wr.addr, `CDOC_ADDR_COUNTS);
    wire logic wr_ctrl = reg_wr_in && addr_hit(wr.addr, `CDOC_ADDR_CTRL);
    wire logic wr_power = reg_wr_in && addr_hit(wr.addr, `CDOC_ADDR_POWER);
    wire logic wr_vco = reg_wr_in && addr_hit(wr.addr, `CDOC_ADDR_VCO);

    // divider counts, low phase in the upper half and high phase in the lower half
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            divider_three_counts_reg <= `CDOC_RESET_BYTE;
        end else if (wr_counts) begin
            divider_three_counts_reg <= wr.data;
        end
    end

    // divider control: bypass, ignore-sync, force, start level and phase offset
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            divider_three_control_reg <= `CDOC_RESET_BYTE;
        end else if (wr_ctrl) begin
            divider_three_control_reg <= wr.data;
        end
    end

    // channel power and routing; unused bits are never stored and read back zero
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            channel_three_power_routing_reg <= `CDOC_RESET_BYTE;
        end else if (wr_power) begin
            channel_three_power_routing_reg <= wr.data & `CDOC_PWR_USED;
        end
    end

    // local copy of the vco divider bypass bit, the only bit kept at that address
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            vco_bypass_reg <= `CDOC_RESET_BYTE;
        end else if (wr_vco) begin
            vco_bypass_reg <= wr.data & `CDOC_VCO_USED;
        end
    end

    // read data stand for the one cycle after the read strobe, zero otherwise
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= reg_rd_in ? rdata_next : 8'h00;
        end
    end

    // chip sync taken through one flop, so a restart always begins on a clock edge
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= sync_in;
        end
    end

    // read selects
    wire logic rd_counts = addr_hit(reg_addr_in, `CDOC_ADDR_COUNTS);
    wire logic rd_ctrl = addr_hit(reg_addr_in, `CDOC_ADDR_CTRL);
    wire logic rd_power = addr_hit(reg_addr_in, `CDOC_ADDR_POWER);
    wire logic rd_vco = addr_hit(reg_addr_in, `CDOC_ADDR_VCO);

    // read decode; unmapped reads give zero so software never sees stale bits
    always_comb begin
        if (rd_counts) begin
            rdata_next = divider_three_counts_reg;
        end else if (rd_ctrl) begin
            rdata_next = divider_three_control_reg;
        end else if (rd_power) begin
            rdata_next = channel_three_power_routing_reg;
        end else if (rd_vco) begin
            rdata_next = vco_bypass_reg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    // control register fields
    wire logic div_bypass = divider_three_control_reg[`CDOC_CTRL_BYPASS];
    wire logic ign_sync = divider_three_control_reg[`CDOC_CTRL_IGNSYNC];
    wire logic force_on = divider_three_control_reg[`CDOC_CTRL_FORCE];
    wire logic start_high = divider_three_control_reg[`CDOC_CTRL_START];

    // power, routing and vco fields
    wire logic pdown = channel_three_power_routing_reg[`CDOC_PWR_DOWN];
    wire logic direct = channel_three_power_routing_reg[`CDOC_PWR_DIRECT];
    wire logic vco_byp = vco_bypass_reg[`CDOC_VCO_BYPASS];

    // count and phase fields handed to the divider
    wire logic [3:0] low_cnt = divider_three_counts_reg[`CDOC_CNT_LOW +: 4];
    wire logic [3:0] high_cnt = divider_three_counts_reg[`CDOC_CNT_HIGH +: 4];
    wire logic [3:0] phase_off = divider_three_control_reg[`CDOC_CTRL_PHASE +: 4];

    // sync restarts the divider only while the channel obeys it
    wire logic do_sync = sync_reg && !ign_sync;

    // static only when forced and ignoring sync, and never when bypassed;
    // forcing without ignore-sync would let the next sync pulse undo it
    wire logic is_static = force_on && ign_sync && !div_bypass;
    wire logic static_lvl = start_high;

    // routing: the direct path counts only while the vco divider is in use
    wire logic use_direct = direct && !vco_byp;
    wire logic div_level = div_bypass ? 1'b1 : div_clk;

    // divider held in reset while bypassed or powered down; on release it
    // always starts from idle with the output low, and takes the start level on the first edge instead of mid-count
    wire logic div_rst_n = rst_n && !div_bypass && !pdown;

    // channel divider, counting reference clock cycles
    cdoc_divider #(.CW(4)) u_cdoc_divider (
        .clk_in(ref_clk_in),
        .rst_n_in(div_rst_n),
        .low_cnt_in(low_cnt),
        .high_cnt_in(high_cnt),
        .phase_in(phase_off),
        .start_high_in(start_high),
        .restart_in(do_sync),
        .static_in(is_static),
        .static_level_in(static_lvl),
        .div_out(div_clk)
    );

    // output selection; direct route marks clock pass-through as a level high
    wire logic src_level = use_direct ? 1'b1 : div_level;
    // driver polarity per output, index 0 is output a; applied after the force
    // and bypass choice, so inversion still works while the divider is bypassed
    wire logic [2:0] pol_map = {polarity_inv_in[0], polarity_inv_in[0], polarity_inv_in[1]};

    // one flop per channel output, cleared while the channel is powered down
    for (genvar i = 0; i < 3; i++) begin : g_out
        always_ff @(posedge ref_clk_in or negedge rst_n) begin
            if (!rst_n) begin
                out_reg[i] <= 1'b0;
            end else if (pdown) begin
                out_reg[i] <= 1'b0;
            end else begin
                out_reg[i] <= src_level ^ pol_map[i];
            end
        end
    end

    // pins and status levels
    assign channel_three_output_a_out = out_reg[0];
    assign channel_three_output_b_out = out_reg[1];
    assign channel_three_output_c_out = out_reg[2];
    assign channel_powered_down_out = pdown;
    assign duty_cycle_fix_en_out = !channel_three_power_routing_reg[`CDOC_PWR_DCCDIS] && !pdown;
endmodule

//--- testbench/cdoc_chk.sv
module cdoc_chk (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [9:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // channel outputs
    input wire logic channel_three_output_a_out,
    input wire logic channel_three_output_b_out,
    input wire logic channel_three_output_c_out,
    input wire logic channel_powered_down_out,
    input wire logic duty_cycle_fix_en_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // address decodes and combined output level
    wire pw = reg_wr_in && reg_addr_in == 10'h19b;
    wire pr = reg_rd_in && reg_addr_in == 10'h19b;
    wire vr = reg_rd_in && reg_addr_in == 10'h1e1;
    wire known = reg_addr_in inside {10'h199, 10'h19a, 10'h19b, 10'h1e1};
    wire outs = channel_three_output_a_out | channel_three_output_b_out | channel_three_output_c_out;
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside read");
    a_pwr_unused: assert property (pr |=> reg_rdata_out[7:3] == 5'h00)
        else $error("unused power bits read back");
    a_vco_unused: assert property (vr |=> reg_rdata_out[7:1] == 7'h00)
        else $error("unused vco bits read back");
    a_unmapped_read: assert property (reg_rd_in && !known |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_pd_write: assert property (pw |=> channel_powered_down_out == $past(reg_wdata_in[2]))
        else $error("power-down flag not updated");
    a_dcc_write: assert property (pw |=> duty_cycle_fix_en_out == (!$past(reg_wdata_in[0]) && !$past(reg_wdata_in[2])))
        else $error("duty fix enable not updated");
    a_pd_hold: assert property (!pw |=> $stable(channel_powered_down_out))
        else $error("power-down flag changed without write");
    a_pd_quiet: assert property (channel_powered_down_out [*2] |-> !outs)
        else $error("output active while powered down");
endmodule

bind cdoc_top cdoc_chk u_cdoc_chk (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .channel_three_output_a_out, .channel_three_output_b_out,
    .channel_three_output_c_out, .channel_powered_down_out, .duty_cycle_fix_en_out);

//--- testbench/cdoc_top_tb.sv
module cdoc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus and observed signals
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [9:0] reg_addr_in = 10'h000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sync_in = 1'b0;
    logic [1:0] polarity_inv_in = 2'h0;
    logic [7:0] reg_rdata_out;
    logic oa, ob, oc, pd, dcc;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    cdoc_top u_cdoc_top (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .sync_in, .polarity_inv_in, .channel_three_output_a_out(oa),
        .channel_three_output_b_out(ob), .channel_three_output_c_out(oc), .channel_powered_down_out(pd),
        .duty_cycle_fix_en_out(dcc));
    // clock and hang guard
    initial forever #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            stop_test();
        end
    end
    task stop_test();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(string nm, logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle register bus cycles
    task wr(logic [9:0] a, logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(logic [9:0] a, logic [7:0] exp);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        chk("read data", reg_rdata_out, exp);
    endtask
    // let registered outputs settle, then compare a, b, c
    task outs(logic [2:0] e);
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk("outputs", {5'h00, oa, ob, oc}, {5'h00, e});
    endtask
    task t_reset();
        rd(10'h199, 8'h00);
        rd(10'h19a, 8'h00);
        rd(10'h19b, 8'h00);
        rd(10'h1e1, 8'h00);
        chk("duty fix", {7'h00, dcc}, 8'h01);
    endtask
    task t_regs();
        wr(10'h19b, 8'hff);
        rd(10'h19b, 8'h07);
        wr(10'h1e1, 8'hff);
        rd(10'h1e1, 8'h01);
        wr(10'h19a, 8'ha5);
        rd(10'h19a, 8'ha5);
        wr(10'h199, 8'h3c);
        rd(10'h199, 8'h3c);
        wr(10'h100, 8'hff);
        rd(10'h100, 8'h00);
        wr(10'h19b, 8'h00);
        wr(10'h1e1, 8'h00);
    endtask
    // count cycles while output a stays at lvl
    task run_len(logic lvl, output int n);
        n = 0;
        while (oa === lvl && n < 40) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask
    // pulse the chip sync, check the start level, then count cycles to the first edge
    task sync_edge(logic lvl, output int n);
        @(posedge ref_clk_in);
        sync_in <= 1'b1;
        @(posedge ref_clk_in);
        sync_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk("start level", {7'h00, oa}, {7'h00, lvl});
        run_len(lvl, n);
    endtask
    // divider after sync: phase delay, then low and high lengths from the counts
    task t_divide();
        int n0, n3, nl, nh;
        wr(10'h199, 8'h21);
        wr(10'h19a, 8'h10);
        sync_edge(1'b1, n0);
        wr(10'h19a, 8'h13);
        sync_edge(1'b1, n3);
        chk("phase delay", 8'(n3 - n0), 8'h03);
        run_len(1'b0, nl);
        chk("low length", 8'(nl), 8'h03);
        run_len(1'b1, nh);
        chk("high length", 8'(nh), 8'h02);
    endtask
    // forced static level under every polarity, sync held active
    task t_force();
        sync_in <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                polarity_inv_in <= 2'(p);
                wr(10'h19a, {3'h3, 1'(s), 4'h3});
                outs({1'(s ^ (p >> 1)), 1'(s ^ p), 1'(s ^ p)});
            end
        end
        sync_in <= 1'b0;
    endtask
    // direct routing, vco bypass, power-down and duty fix
    task t_route();
        polarity_inv_in <= 2'h2;
        wr(10'h19a, 8'h63);
        wr(10'h19b, 8'h02);
        outs(3'h3);
        wr(10'h1e1, 8'h01);
        outs(3'h4);
        wr(10'h1e1, 8'h00);
        wr(10'h19b, 8'h06);
        outs(3'h0);
        chk("power-down", {7'h00, pd}, 8'h01);
        wr(10'h19b, 8'h01);
        @(negedge ref_clk_in);
        chk("duty fix", {7'h00, dcc}, 8'h00);
        wr(10'h19b, 8'h00);
        @(negedge ref_clk_in);
        chk("duty fix", {7'h00, dcc}, 8'h01);
        chk("power-down", {7'h00, pd}, 8'h00);
        wr(10'h19a, 8'he3);
        outs(3'h3);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        t_reset();
        t_regs();
        t_divide();
        t_force();
        t_route();
        stop_test();
    end
endmodule
